// ### rtl/mfr_top.sv
// malfunction detection, stop sequencing, segment guard and transfer check
`timescale 1ns/100ps
`default_nettype none
`include "mfr_cfg.svh"
// How it works
// [RULE1] a detected or likely malfunction sends the block from run into the stopped state.
// [RULE2] in the stopped state cpu reset and halt are asserted and all i/o is disabled.
// [RULE3] while stopped every register of the block returns to its reset value; the code keeps the alarm sync flops running.
// [RULE4] a nonvolatile word with two or more bad bits raises an exception pulse to the cpu; the code flags only even-weight errors with a nonzero syndrome.
// [RULE5] a nonvolatile word with one bad bit is delivered corrected with no exception.
// [RULE6] each segment access is granted or denied from its address alone; the code also uses the access type and that segment's rights.
// [RULE7] software sets segmentation and rights through dedicated configuration inputs.
// [RULE8] accesses outside the target range or segment rights, or cpu faults, are malfunctions.
// [RULE9] internal transfers carry dual-rail data plus parity so corruption is detectable.
// [RULE10] a parity or dual-rail mismatch is a malfunction and triggers the stopped state.
module mfr_top
  import mfr_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  input  wire logic                   sensor_alarm,
  input  wire logic                   cpu_fault,
  input  wire mfr_access_type         access,
  input  wire logic                   cfg_write,
  input  wire logic [`MFR_ADDR_W-1:0] cfg_base,
  input  wire logic [`MFR_ADDR_W-1:0] cfg_span,
  input  wire mfr_rights_type         cfg_rights,
  input  wire mfr_xfer_type           xfer,
  input  wire logic                   nvm_valid,
  input  wire logic [`MFR_CODE_W-1:0] nvm_code,
  output logic                        access_grant,
  output logic                        access_deny,
  output logic                        nvm_data_valid,
  output logic [`MFR_DATA_W-1:0]      nvm_data,
  output logic                        nvm_exception,
  output logic                        cpu_reset,
  output logic                        cpu_halt,
  output logic                        io_disable,
  output logic                        stopped
);
  //////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    mfr_mode_type            mode;
    logic [`MFR_CNT_W-1:0]   cnt;
    logic                    alarm_sync;
    logic                    alarm_meta;
    logic [`MFR_ADDR_W-1:0]  base;
    logic [`MFR_ADDR_W-1:0]  span;
    mfr_rights_type          rights;
    logic                    grant;
    logic                    deny;
  } mfr_state_type;

  mfr_state_type st;
  mfr_state_type next_st;
  logic          ecc_valid;
  logic [`MFR_DATA_W-1:0] ecc_data;
  logic          ecc_multi;
  logic          ecc_fix;
  logic          seg_viol;
  logic          xfer_bad;
  logic          malfunction;
  logic          core_reset;

  // segment index from the top offset bits above base, zero for a zero span
  function automatic logic [`MFR_SEG_IDX_W-1:0] mfr_seg_of(
    input logic [`MFR_ADDR_W-1:0] a, input logic [`MFR_ADDR_W-1:0] b,
    input logic [`MFR_ADDR_W-1:0] s);
    logic [`MFR_ADDR_W-1:0] off;
    off = a - b;
    return off[`MFR_ADDR_W-1 -: `MFR_SEG_IDX_W] & {`MFR_SEG_IDX_W{s != '0}};
  endfunction : mfr_seg_of

  function automatic logic mfr_allowed(input mfr_access_type a, input mfr_right_type r);
    return a.fetch ? r.ex : (a.write ? r.wr : r.rd);
  endfunction : mfr_allowed

  //////////////////////////////////////////////////////////////////////////////
  // the stopped state also scrubs the ecc decoder
  assign core_reset = reset || (st.mode == MFR_STOP);                   // RULE3

  mfr_ecc u_ecc (
    .sys_clk    (sys_clk),
    .reset      (core_reset),
    .code_valid (nvm_valid),
    .code       (nvm_code),
    .data_valid (ecc_valid),
    .data       (ecc_data),
    .single_fix (ecc_fix),
    .multi_err  (ecc_multi)
  );

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic in_range;
    logic [`MFR_SEG_IDX_W-1:0] idx;
    in_range = (access.addr >= st.base) && (access.addr - st.base < st.span); // RULE6
    idx      = mfr_seg_of(access.addr, st.base, st.span);
    seg_viol = access.valid && st.mode == MFR_RUN
               && (!in_range || !mfr_allowed(access, st.rights[idx]));      // RULE8
  end

  // each rail must be the other's complement and parity must match
  assign xfer_bad = xfer.valid
                    && ((xfer.data_t != ~xfer.data_f)
                        || (^xfer.data_t != xfer.parity));                // RULE9
  assign malfunction = st.alarm_sync || cpu_fault || seg_viol
                       || xfer_bad;                                        // RULE10

  always_comb
  begin
    next_st = st;
    // sensor level is asynchronous: two flops, and only the second is read
    next_st.alarm_meta = sensor_alarm;
    next_st.alarm_sync = st.alarm_meta;
    next_st.grant = 1'b0;
    next_st.deny  = 1'b0;
    case (st.mode)
      MFR_RUN:
      begin
        if (cfg_write)
        begin
          next_st.base   = cfg_base;                                        // RULE7
          next_st.span   = cfg_span;
          next_st.rights = cfg_rights;
        end
        next_st.grant = access.valid && !seg_viol;                          // RULE6
        next_st.deny  = seg_viol;
        if (malfunction)
        begin
          next_st.mode = MFR_STOP;                                          // RULE1
          next_st.cnt  = `MFR_STOP_CYC;
        end
      end
      MFR_STOP:
      begin
        // registers go back to reset values; sensor sync keeps watching
        next_st.base   = `MFR_SEG_LO;                                       // RULE3
        next_st.span   = `MFR_SEG_HI;
        next_st.rights = `MFR_RIGHTS_RST;
        // a lasting alarm keeps the chip stopped; the count restarts each cycle
        if (st.alarm_sync)
          next_st.cnt = `MFR_STOP_CYC;
        else if (st.cnt != `MFR_CNT_ZERO)
          next_st.cnt = st.cnt - `MFR_CNT_ONE;
        else
          next_st.mode = MFR_RUN;
      end
      default:
        next_st.mode = MFR_STOP;
    endcase
  end

  always_ff @(posedge sys_clk)
    if (reset)
    begin
      st        <= '0;
      st.mode   <= MFR_RUN;
      st.base   <= `MFR_SEG_LO;
      st.span   <= `MFR_SEG_HI;
      st.rights <= `MFR_RIGHTS_RST;
    end
    else
      st <= next_st;

  //////////////////////////////////////////////////////////////////////////////
  assign stopped        = (st.mode == MFR_STOP);
  assign cpu_reset      = stopped;                                          // RULE2
  assign cpu_halt       = stopped;
  assign io_disable     = stopped;
  assign access_grant   = st.grant;
  assign access_deny    = st.deny;
  assign nvm_data_valid = ecc_valid;
  assign nvm_data       = ecc_data;                                         // RULE5
  assign nvm_exception  = ecc_multi;                                        // RULE4

  //////////////////////////////////////////////////////////////////////////////
  // entry, hold and exit of the stopped state, plus segment, ecc and transfer checks
  sequence s_fault;
    st.mode == MFR_RUN && malfunction;
  endsequence
  sequence s_stop_held;
    cpu_reset && cpu_halt && io_disable;
  endsequence
  sequence s_alarm_seen;
    stopped && st.alarm_sync;
  endsequence
  sequence s_stop_quiet;
    !access_grant && !access_deny && !nvm_data_valid && !nvm_exception;
  endsequence
  sequence s_run_ok;
    access.valid && st.mode == MFR_RUN && !seg_viol;
  endsequence

  a_fault_stops : assert property (@(posedge sys_clk) disable iff (reset) // RULE1
    s_fault |=> stopped) else $error("malfunction did not stop");
  a_alarm_hold : assert property (@(posedge sys_clk) disable iff (reset) // RULE1
    s_alarm_seen |=> stopped [*8]) else $error("alarm did not hold the stop");
  a_stop_outputs : assert property (@(posedge sys_clk) disable iff (reset) // RULE2
    stopped |-> s_stop_held) else $error("stop outputs missing");
  a_stop_quiet : assert property (@(posedge sys_clk) disable iff (reset) // RULE3
    stopped |=> s_stop_quiet) else $error("outputs active while stopped");
  a_stop_scrub : assert property (@(posedge sys_clk) disable iff (reset) // RULE3
    stopped |=> st.rights == `MFR_RIGHTS_RST) else $error("rights not reset");
  a_stop_exit : assert property (@(posedge sys_clk) disable iff (reset) // RULE3
    $fell(stopped) |-> st.base == `MFR_SEG_LO && st.span == `MFR_SEG_HI)
    else $error("segment map not reset");
  a_stop_min : assert property (@(posedge sys_clk) disable iff (reset) // RULE3
    s_fault |=> stopped [*8]) else $error("stop too short");
  a_multi_exc : assert property (@(posedge sys_clk) disable iff (reset) // RULE4
    nvm_exception |-> nvm_data_valid && !ecc_fix) else $error("bad exception");
  a_seg_deny : assert property (@(posedge sys_clk) disable iff (reset) // RULE6
    seg_viol |=> access_deny && !access_grant) else $error("violation granted");
  a_grant_ok : assert property (@(posedge sys_clk) disable iff (reset) // RULE6
    s_run_ok |=> access_grant && !access_deny) else $error("legal access not granted");
  a_viol_stop : assert property (@(posedge sys_clk) disable iff (reset) // RULE8
    seg_viol |=> stopped) else $error("violation did not stop");
  a_range_viol : assert property (@(posedge sys_clk) disable iff (reset) // RULE8
    (access.valid && st.mode == MFR_RUN && access.addr < st.base) |-> seg_viol)
    else $error("access below base not flagged");
  a_xfer_stop : assert property (@(posedge sys_clk) disable iff (reset) // RULE10
    (xfer_bad && !stopped) |=> stopped ##1 io_disable) else $error("xfer fault missed");
  a_rail_check : assert property (@(posedge sys_clk) disable iff (reset) // RULE9
    (xfer.valid && xfer.data_t == xfer.data_f) |-> xfer_bad) else $error("rails unchecked");
endmodule : mfr_top
`default_nettype wire

// ### rtl/mfr_cfg.svh
// constants for the malfunction fault response block
`ifndef MFR_CFG_SVH
`define MFR_CFG_SVH
`define MFR_ADDR_W      16
`define MFR_DATA_W      8
`define MFR_CODE_W      13
`define MFR_SEG_N       4
`define MFR_SEG_IDX_W   2
`define MFR_SEG_LO      16'h0000
`define MFR_SEG_HI      16'h3fff
`define MFR_RIGHTS_RST  12'h000
`define MFR_STOP_CYC    4'h8
`define MFR_CNT_W       4
`define MFR_CNT_ZERO    4'h0
`define MFR_CNT_ONE     4'h1
`endif

// ### rtl/mfr_pkg.sv
// types shared by the malfunction fault response block
`include "mfr_cfg.svh"
package mfr_pkg;
  // one access request from the cpu
  typedef struct packed {
    logic                    valid;
    logic                    write;
    logic                    fetch;
    logic [`MFR_ADDR_W-1:0]  addr;
  } mfr_access_type;
  // per segment rights: read, write, execute
  typedef struct packed {
    logic rd;
    logic wr;
    logic ex;
  } mfr_right_type;
  typedef mfr_right_type [`MFR_SEG_N-1:0] mfr_rights_type;
  // dual-rail transfer with parity
  typedef struct packed {
    logic                    valid;
    logic [`MFR_DATA_W-1:0]  data_t;
    logic [`MFR_DATA_W-1:0]  data_f;
    logic                    parity;
  } mfr_xfer_type;
  typedef enum logic [1:0] {
    MFR_RUN  = 2'b01,
    MFR_STOP = 2'b10
  } mfr_mode_type;
endpackage : mfr_pkg

// ### rtl/mfr_ecc.sv
// single-error-correct double-error-detect decoder for nonvolatile words
`timescale 1ns/100ps
`default_nettype none
`include "mfr_cfg.svh"
module mfr_ecc
  import mfr_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  input  wire logic                   code_valid,
  input  wire logic [`MFR_CODE_W-1:0] code,
  output logic                        data_valid,
  output logic [`MFR_DATA_W-1:0]      data,
  output logic                        single_fix,
  output logic                        multi_err
);
  // hamming(12,8) positions 1..12, bit 0 is overall parity
  typedef struct packed {
    logic                   data_valid;
    logic [`MFR_DATA_W-1:0] data;
    logic                   single_fix;
    logic                   multi_err;
  } mfr_ecc_state_type;

  mfr_ecc_state_type st;
  mfr_ecc_state_type next_st;

  function automatic logic [3:0] mfr_syndrome(input logic [`MFR_CODE_W-1:0] c);
    logic [3:0] s;
    s = 4'h0;
    for (int i = 1; i < `MFR_CODE_W; i++)
      if (c[i])
        s = s ^ i[3:0];
    return s;
  endfunction : mfr_syndrome

  always_comb
  begin
    logic [3:0]             syn;
    logic                   par;
    logic [`MFR_CODE_W-1:0] fixed;
    syn     = mfr_syndrome(code);
    par     = ^code;
    fixed   = code;
    next_st = st;
    next_st.data_valid = code_valid;
    next_st.single_fix = 1'b0;
    next_st.multi_err  = 1'b0;
    if (code_valid)
    begin
      if (syn != 4'h0 && !par)
        next_st.multi_err = 1'b1;                     // RULE4
      else if (par)
      begin
        next_st.single_fix = 1'b1;                    // RULE5
        if (syn < 4'hd)
          fixed[syn] = ~fixed[syn];
      end
      next_st.data = {fixed[12:9], fixed[7:5], fixed[3]};
    end
  end

  always_ff @(posedge sys_clk)
    if (reset)
      st <= '0;
    else
      st <= next_st;

  assign data_valid = st.data_valid;
  assign data       = st.data;
  assign single_fix = st.single_fix;
  assign multi_err  = st.multi_err;

  // an odd-weight word must come out corrected, never as an exception
  a_single_no_exc : assert property (@(posedge sys_clk) disable iff (reset) // RULE5
    (code_valid && ^code) |=> single_fix && !multi_err) else $error("single error not fixed");
endmodule : mfr_ecc
`default_nettype wire

// ### bench/mfr_nvm_model.sv
// eeprom far-side model: encodes a data byte and injects bit flips on request
`timescale 1ns/100ps
`default_nettype none
`include "mfr_cfg.svh"
module mfr_nvm_model
  import mfr_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  input  wire logic                   req,
  input  wire logic [`MFR_DATA_W-1:0] wdata,
  input  wire logic [`MFR_CODE_W-1:0] flip,
  output logic                        nvm_valid,
  output logic [`MFR_CODE_W-1:0]      nvm_code
);
  logic [`MFR_CODE_W-1:0] enc;
  always_comb
  begin
    enc = '0;
    {enc[12:9], enc[7:5], enc[3]} = wdata;
    enc[1] = enc[3] ^ enc[5] ^ enc[7] ^ enc[9] ^ enc[11];
    enc[2] = enc[3] ^ enc[6] ^ enc[7] ^ enc[10] ^ enc[11];
    enc[4] = enc[5] ^ enc[6] ^ enc[7] ^ enc[12];
    enc[8] = ^enc[12:9];
    enc[0] = ^enc[12:1];
  end
  // between words the bus is not held: the inverse keeps stale data from passing as a word
  always_ff @(posedge sys_clk)
  begin
    nvm_valid <= req & ~reset;
    nvm_code  <= reset ? 13'h0000 : (req ? enc ^ flip : ~nvm_code);
  end
endmodule : mfr_nvm_model
`default_nettype wire

// ### bench/tb_malfunction_fault_response.sv
// self-checking bench for the malfunction fault response block
`timescale 1ns/100ps
`default_nettype none
`include "mfr_cfg.svh"
module tb_malfunction_fault_response
  import mfr_pkg::*;
  ;
  logic           sys_clk = 1'h0;
  logic           reset = 1'h1;
  logic           sensor_alarm = 1'h0;
  logic           cpu_fault = 1'h0;
  mfr_access_type access = '0;
  logic           cfg_write = 1'h0;
  logic [15:0]    cfg_base = 16'h0000;
  logic [15:0]    cfg_span = 16'h0000;
  mfr_rights_type cfg_rights = '0;
  mfr_xfer_type   xfer = '0;
  logic           req = 1'h0;
  logic [7:0]     wdata = 8'h00;
  logic [12:0]    flip = 13'h0000;
  logic           nvm_valid, grant, deny, dval, exc;
  logic           cpu_reset, cpu_halt, io_disable, stopped;
  logic [12:0]    nvm_code;
  logic [7:0]     nvm_data;
  int             errors = 0;
  int             comparisons = 0;
  mfr_nvm_model nvm (.sys_clk(sys_clk), .reset(reset), .req(req), .wdata(wdata), .flip(flip),
    .nvm_valid(nvm_valid), .nvm_code(nvm_code));
  mfr_top dut (.sys_clk(sys_clk), .reset(reset), .sensor_alarm(sensor_alarm),
    .cpu_fault(cpu_fault), .access(access), .cfg_write(cfg_write), .cfg_base(cfg_base),
    .cfg_span(cfg_span), .cfg_rights(cfg_rights), .xfer(xfer), .nvm_valid(nvm_valid),
    .nvm_code(nvm_code), .access_grant(grant), .access_deny(deny), .nvm_data_valid(dval),
    .nvm_data(nvm_data), .nvm_exception(exc), .cpu_reset(cpu_reset), .cpu_halt(cpu_halt),
    .io_disable(io_disable), .stopped(stopped));
  always #10 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic final_report;
    if (errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////////////
  // access stays valid on return so callers can run accesses back to back
  task automatic do_access(input logic wr, input logic fe, input logic [15:0] a, input logic ok);
    access = '{1'h1, wr, fe, a};
    tick();
    chk_bit(grant, ok);
    chk_bit(deny, ~ok);
    chk_bit(stopped, ~ok);
  endtask : do_access
  // triggers are one-cycle pulses: cleared after the first edge that can take them
  task automatic stop_check(input int lat, input int len);
    int n;
    int m;
    n = 0;
    m = 0;
    while (stopped !== 1'h1 && n < 20)
    begin
      tick();
      n++;
      sensor_alarm = 1'h0;
      cpu_fault = 1'h0;
      xfer.valid = 1'h0;
    end
    if (stopped !== 1'h1)
    begin
      errors++;
      final_report();
    end
    chk_val(16'(n), 16'(lat));
    chk_bit(cpu_reset & cpu_halt & io_disable, 1'h1);
    while (stopped === 1'h1 && m < 30)
    begin
      tick();
      m++;
    end
    if (stopped === 1'h1)
    begin
      errors++;
      final_report();
    end
    if (len > 0)
      chk_val(16'(m), 16'(len));
    chk_bit(cpu_reset | cpu_halt | io_disable, 1'h0);
  endtask : stop_check
  task automatic nvm_word(input logic [7:0] d, input logic [12:0] f, input logic e);
    wdata = d;
    flip = f;
    req = 1'h1;
    tick();
    req = 1'h0;
    tick();
    chk_bit(dval, 1'h1);
    chk_bit(exc, e);
    if (!e)
      chk_val(16'(nvm_data), 16'(d));
  endtask : nvm_word
  ////////////////////////////////////////////////////////////////////////////////
  task automatic s_segments;
    cfg_base = 16'h0000;
    cfg_span = 16'hffff;
    cfg_rights = mfr_rights_type'(12'he74);
    cfg_write = 1'h1;
    tick();
    cfg_write = 1'h0;
    do_access(1'h0, 1'h0, 16'h0010, 1'h1);
    do_access(1'h1, 1'h0, 16'h4000, 1'h1);
    do_access(1'h0, 1'h1, 16'h8000, 1'h1);
    do_access(1'h1, 1'h0, 16'hc000, 1'h1);
    do_access(1'h0, 1'h0, 16'h8004, 1'h0);
    access.valid = 1'h0;
    stop_check(0, 9);
    do_access(1'h0, 1'h0, 16'h0010, 1'h0);
    access.valid = 1'h0;
    stop_check(0, 9);
  endtask : s_segments
  task automatic s_nvm;
    nvm_word(8'h3c, 13'h0000, 1'h0);
    for (int i = 0; i < 13; i++)
      nvm_word(8'ha5 ^ 8'(i), 13'h0001 << i, 1'h0);
    for (int i = 1; i < 12; i++)
      nvm_word(8'h69, 13'h0003 << i, 1'h1);
  endtask : s_nvm
  task automatic s_faults;
    xfer = '{1'h1, 8'h5a, 8'ha5, 1'h0};
    tick();
    tick();
    chk_bit(stopped, 1'h0);
    xfer = '{1'h1, 8'h5a, 8'ha5, 1'h1};
    stop_check(1, 9);
    xfer = '{1'h1, 8'h5a, 8'ha4, 1'h0};
    stop_check(1, 9);
    xfer = '{1'h1, 8'h5a, 8'h5a, 1'h0};
    stop_check(1, 9);
    cpu_fault = 1'h1;
    stop_check(1, 9);
    sensor_alarm = 1'h1;
    stop_check(3, 9);
  endtask : s_faults
  task automatic s_range;
    cfg_base = 16'h1000;
    cfg_span = 16'h2000;
    cfg_rights = mfr_rights_type'(12'hfff);
    cfg_write = 1'h1;
    tick();
    cfg_write = 1'h0;
    do_access(1'h0, 1'h0, 16'h1000, 1'h1);
    do_access(1'h1, 1'h0, 16'h2fff, 1'h1);
    do_access(1'h0, 1'h0, 16'h3000, 1'h0);
    access.valid = 1'h0;
    stop_check(0, 9);
    cfg_write = 1'h1;
    tick();
    cfg_write = 1'h0;
    do_access(1'h0, 1'h1, 16'h0fff, 1'h0);
    access.valid = 1'h0;
    stop_check(0, 9);
  endtask : s_range
  // a held alarm keeps the chip stopped: release takes two sync stages, the count and the exit
  task automatic s_alarm_hold;
    int k;
    k = 0;
    sensor_alarm = 1'h1;
    repeat (6) tick();
    chk_bit(stopped, 1'h1);
    sensor_alarm = 1'h0;
    while (stopped === 1'h1 && k < 30)
    begin
      tick();
      k++;
    end
    if (stopped === 1'h1)
    begin
      errors++;
      final_report();
    end
    chk_val(16'(k), 16'(`MFR_STOP_CYC) + 16'h0003);
  endtask : s_alarm_hold
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge sys_clk);
    #1;
    reset = 1'h0;
    tick();
    chk_bit(stopped | cpu_reset | cpu_halt | io_disable, 1'h0);
    chk_bit(grant | deny | exc, 1'h0);
    s_segments();
    s_nvm();
    s_faults();
    s_range();
    s_alarm_hold();
    final_report();
  end
endmodule : tb_malfunction_fault_response
`default_nettype wire
